// ### design/card_pin_device.sv
// Card end of the multiplexed pin functions.
`timescale 1ns/10ps
`include "card_pin_params.svh"
module card_pin_device
  import card_pin_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pins toward the socket.
  card_pin_if.card pins,
  // Card-side control.
  input wire mode_type mode,
  input wire logic cardReady,
  input wire logic writeProtect,
  input wire logic [`CCSR_WIDTH-1:0] configStatus,
  input wire logic driveBusy,
  input wire logic passDiagDrive,
  // Decode results.
  output region_type region,
  output logic [`TASK_SEL_WIDTH-1:0] taskRegSel,
  output logic isMaster,
  output logic slaveSeen,
  output logic peerDiagPassed,
  output logic statusChangedN,
  output logic audioOutN
);
  // *****************************************************
  // Pin synchronisers
  // *****************************************************
  // Address bits settle independently, so a decode may see a mixed
  // address for one cycle while the host changes it; the host holds
  // each address for many cycles, so the outputs settle behind it.
  logic [10:0] addrMeta;
  logic [10:0] addrSync;
  // Control pins: attribute select, cable select and pass diagnostic.
  logic [2:0] ctlMeta;
  logic [2:0] ctlSync;
  // Last cycle's ready and write-protect levels.
  logic readySync;
  logic wprotSync;

  // Async pins pass two flops before any decode reads them.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addrMeta <= `ADDR_RESET;
      addrSync <= `ADDR_RESET;
      ctlMeta <= `CTL_IDLE;
      ctlSync <= `CTL_IDLE;
    end else begin
      addrMeta <= pins.cardAddressBus;
      addrSync <= addrMeta;
      ctlMeta <= {pins.attributeSelectN, pins.cableSelectN,
                  pins.passDiagnosticN};
      ctlSync <= ctlMeta;
    end
  end

  // Drive-active pin is synchronised separately, also two stages.
  logic dashMeta, dashSync;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dashMeta <= 1'b1;
      dashSync <= 1'b1;
    end else begin
      dashMeta <= pins.driveActiveSlavePresentN;
      dashSync <= dashMeta;
    end
  end

  // *****************************************************
  // Address decode
  // *****************************************************
  function automatic region_type decodeRegion(input logic [10:0] a,
                                              input logic attrN,
                                              input mode_type m);
    region_type r;
    r = REGION_MEM_PORT;
    if (!attrN && a < `ATTR_CIS_LIMIT) begin
      r = REGION_CIS;
    end else if (!attrN) begin
      r = REGION_CONFIG;
    end else if (m == MODE_IO) begin
      r = REGION_IO_PORT;
    end
    return r;
  endfunction

  // Task-file mode changes the meaning of several pins at once.
  function automatic logic isTaskFile(input mode_type m);
    return m == MODE_TASKFILE;
  endfunction

  // Card modes use all eleven lines plus attribute select.
  // Task-file mode parks the region on the I/O port so that a stale
  // card-mode decode never reaches the register file.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      region <= REGION_MEM_PORT;
    end else if (!isTaskFile(mode)) begin
      region <= decodeRegion(addrSync, ctlSync[`CTL_ATTR_BIT],
                             mode);
    end else begin
      region <= REGION_IO_PORT;
    end
  end

  // Upper lines are ignored; the host is expected to ground them.
  // The select holds its last value outside task-file mode, so a mode
  // switch does not disturb a register pointer still in use.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      taskRegSel <= '0;
    end else if (isTaskFile(mode)) begin
      taskRegSel <= addrSync[`TASK_SEL_WIDTH-1:0];
    end
  end

  // *****************************************************
  // Status changed and audio
  // *****************************************************
  // Previous ready and write-protect for change detection.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readySync <= 1'b0;
      wprotSync <= 1'b0;
    end else begin
      readySync <= cardReady;
      wprotSync <= writeProtect;
    end
  end

  // Change alert is gated by the enable bit; active only in I/O mode.
  // The alert is a one-cycle pulse, not a sticky flag: a host that does
  // not sample every cycle loses the event, traded for no clear path.
  logic next_statusChangedN;
  always_comb begin
    next_statusChangedN = 1'b1;
    if (mode == MODE_IO && configStatus[`CCSR_CHGEN_BIT] &&
        (readySync != cardReady || wprotSync != writeProtect)) begin
      next_statusChangedN = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      statusChangedN <= 1'b1;
      audioOutN <= 1'b1;
    end else begin
      statusChangedN <= next_statusChangedN;
      audioOutN <= 1'b1;
    end
  end

  // *****************************************************
  // Fixed pins and handshake
  // *****************************************************
  // Battery detect not supported, so both outputs stay high in memory
  // mode; the same pins carry the alert and audio in I/O mode.
  // Card detects are tied low in every mode; they are registered only
  // so that every pin of the card leaves a flop.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins.batteryDetectOne <= 1'b1;
      pins.batteryDetectTwo <= 1'b1;
      pins.cardDetectOneN <= 1'b0;
      pins.cardDetectTwoN <= 1'b0;
    end else begin
      pins.cardDetectOneN <= 1'b0;
      pins.cardDetectTwoN <= 1'b0;
      if (mode == MODE_IO) begin
        pins.batteryDetectOne <= next_statusChangedN;
        pins.batteryDetectTwo <= 1'b1;
      end else begin
        pins.batteryDetectOne <= 1'b1;
        pins.batteryDetectTwo <= 1'b1;
      end
    end
  end

  // Master when cable select is grounded; pulled up means slave.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      isMaster <= 1'b0;
      slaveSeen <= 1'b0;
      peerDiagPassed <= 1'b0;
    end else begin
      isMaster <= isTaskFile(mode) && !ctlSync[`CTL_CABLE_SELECT_N_BIT];
      slaveSeen <= isTaskFile(mode) && !dashSync;
      peerDiagPassed <= isTaskFile(mode) && !ctlSync[`CTL_DIAG_BIT];
    end
  end

  // Open-drain drive: only pulls low, and only in task-file mode.
  // As slave the card shows its presence continuously; as master it
  // pulls the activity line only while the drive is busy.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins.passDiagCardOut <= 1'b0;
      pins.passDiagCardOe <= 1'b0;
      pins.driveActiveCardOut <= 1'b0;
      pins.driveActiveCardOe <= 1'b0;
    end else begin
      pins.passDiagCardOut <= 1'b0;
      pins.driveActiveCardOut <= 1'b0;
      pins.passDiagCardOe <= isTaskFile(mode) && passDiagDrive;
      pins.driveActiveCardOe <= isTaskFile(mode) &&
                                (driveBusy || !isMaster);
    end
  end
endmodule

// ### design/card_pin_host.sv
// Socket end of the multiplexed pin functions.
`timescale 1ns/10ps
`include "card_pin_params.svh"
module card_pin_host
  import card_pin_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pins toward the card.
  card_pin_if.host pins,
  // Host-side control.
  input wire mode_type mode,
  input wire logic [10:0] hostAddress,
  input wire logic attributeAccess,
  input wire logic selectMaster,
  input wire logic hostDiagDrive,
  // Host-side status.
  output logic cardInserted,
  output logic statusAlert,
  output logic driveActiveSeen
);
  // *****************************************************
  // Pin outputs
  // *****************************************************
  // Task-file mode changes the meaning of several pins at once.
  function automatic logic isTaskFile(input mode_type m);
    return m == MODE_TASKFILE;
  endfunction

  // Upper address lines grounded in task-file mode.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins.cardAddressBus <= `ADDR_RESET;
      pins.attributeSelectN <= 1'b1;
      pins.cableSelectN <= 1'b1;
      pins.passDiagHostOut <= 1'b0;
      pins.passDiagHostOe <= 1'b0;
      pins.driveActiveHostOut <= 1'b0;
      pins.driveActiveHostOe <= 1'b0;
    end else begin
      if (isTaskFile(mode)) begin
        pins.cardAddressBus <= {`UPPER_ZERO,
          hostAddress[`TASK_SEL_WIDTH-1:0]};
      end else begin
        pins.cardAddressBus <= hostAddress;
      end
      pins.attributeSelectN <= !attributeAccess;
      pins.cableSelectN <= !selectMaster;
      pins.passDiagHostOut <= 1'b0;
      pins.passDiagHostOe <= isTaskFile(mode) &&
                             hostDiagDrive;
      pins.driveActiveHostOut <= 1'b0;
      pins.driveActiveHostOe <= 1'b0;
    end
  end

  // *****************************************************
  // Pin inputs
  // *****************************************************
  logic [3:0] inMeta, inSync;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inMeta <= `HOST_IN_IDLE;
      inSync <= `HOST_IN_IDLE;
    end else begin
      inMeta <= {pins.cardDetectOneN, pins.cardDetectTwoN,
                 pins.batteryDetectOne, pins.driveActiveSlavePresentN};
      inSync <= inMeta;
    end
  end

  // Insertion needs both detects low so a tilted card is not seen.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cardInserted <= 1'b0;
      statusAlert <= 1'b0;
      driveActiveSeen <= 1'b0;
    end else begin
      cardInserted <= !inSync[`HOST_CD1_BIT] &&
                      !inSync[`HOST_CD2_BIT];
      statusAlert <= (mode == MODE_IO) &&
                     !inSync[`HOST_ALERT_BIT];
      driveActiveSeen <= isTaskFile(mode) &&
                         !inSync[`HOST_ACTIVE_BIT];
    end
  end
endmodule

// ### dv/card_pin_checker.sv
// Concurrent checks on the card pins between socket and card.
`timescale 1ns/10ps
module card_pin_checker
  import card_pin_pkg::*;
(
  // Clock, reset and mode.
  input wire logic clk,
  input wire logic rstn,
  input wire mode_type mode,
  // Pins.
  input wire logic [10:0] cardAddressBus,
  input wire logic batteryDetectOne,
  input wire logic batteryDetectTwo,
  input wire logic cardDetectOneN,
  input wire logic cardDetectTwoN,
  input wire logic cableSelectN,
  input wire logic passDiagCardOe,
  input wire logic driveActiveCardOe,
  input wire logic driveActiveSlavePresentN
);
  // ****************************************
  // Mode windows
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Registered pins lag the mode, so each mode-window check waits for a steady mode.
  sequence memSteady; (mode == MODE_MEMORY) [*3]; endsequence
  sequence ioSteady; (mode == MODE_IO) [*3]; endsequence
  sequence tfSteady; (mode == MODE_TASKFILE) [*2]; endsequence
  sequence cardModes; (mode != MODE_TASKFILE) [*3]; endsequence
  sequence slaveSteady; (mode == MODE_TASKFILE && cableSelectN) [*6];
  endsequence
  chk_detect_low: assert property (!cardDetectOneN && !cardDetectTwoN)
    else $error("card detect pins not low");
  chk_battery_high: assert property
    (memSteady |-> batteryDetectOne && batteryDetectTwo)
    else $error("battery detects not high in memory mode");
  chk_audio_negated: assert property (ioSteady |-> batteryDetectTwo)
    else $error("audio pin asserted in io mode");
  chk_alert_width: assert property
    ($fell(batteryDetectOne) |=> batteryDetectOne)
    else $error("status alert longer than one cycle");
  chk_alert_mode: assert property
    ($fell(batteryDetectOne) |-> $past(mode) == MODE_IO)
    else $error("status alert outside io mode");
  chk_upper_zero: assert property
    (tfSteady |-> cardAddressBus[10:3] == 8'h00)
    else $error("upper address lines driven in task-file mode");
  chk_handshake_idle: assert property
    (cardModes |-> !passDiagCardOe && !driveActiveCardOe)
    else $error("handshake pin driven outside task-file mode");
  chk_slave_present: assert property
    (slaveSteady |-> !driveActiveSlavePresentN)
    else $error("slave card not showing presence");
  cov_alert: cover property ($fell(batteryDetectOne));
endmodule

// ### dv/card_pin_tb.sv
// Bench joining both card pin ends and checking their pin functions.
`timescale 1ns/10ps
`define CHECK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
  errorCnt++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
  end end
module card_host_pin_functions_tb;
  import card_pin_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic clk, rstn, cardReady, writeProtect, driveBusy, passDiagDrive;
  logic attributeAccess, selectMaster, hostDiagDrive;
  logic isMaster, slaveSeen, peerDiagPassed, statusChangedN, audioOutN;
  logic cardInserted, statusAlert, driveActiveSeen;
  logic [7:0] configStatus;
  logic [10:0] hostAddress;
  logic [2:0] taskRegSel;
  mode_type mode;
  region_type region;
  int errorCnt = 0;
  int samplesChecked = 0;
  int cycles = 0;
  card_pin_if pins();
  card_pin_device u_card_pin_device (.clk(clk), .rstn(rstn), .pins(pins),
    .mode(mode), .cardReady(cardReady), .writeProtect(writeProtect),
    .configStatus(configStatus), .driveBusy(driveBusy),
    .passDiagDrive(passDiagDrive), .region(region), .taskRegSel(taskRegSel),
    .isMaster(isMaster), .slaveSeen(slaveSeen),
    .peerDiagPassed(peerDiagPassed), .statusChangedN(statusChangedN),
    .audioOutN(audioOutN));
  card_pin_host u_card_pin_host (.clk(clk), .rstn(rstn), .pins(pins),
    .mode(mode), .hostAddress(hostAddress),
    .attributeAccess(attributeAccess), .selectMaster(selectMaster),
    .hostDiagDrive(hostDiagDrive), .cardInserted(cardInserted),
    .statusAlert(statusAlert), .driveActiveSeen(driveActiveSeen));
  card_pin_checker u_card_pin_checker (.clk(clk), .rstn(rstn), .mode(mode),
    .cardAddressBus(pins.cardAddressBus),
    .batteryDetectOne(pins.batteryDetectOne),
    .batteryDetectTwo(pins.batteryDetectTwo),
    .cardDetectOneN(pins.cardDetectOneN),
    .cardDetectTwoN(pins.cardDetectTwoN), .cableSelectN(pins.cableSelectN),
    .passDiagCardOe(pins.passDiagCardOe),
    .driveActiveCardOe(pins.driveActiveCardOe),
    .driveActiveSlavePresentN(pins.driveActiveSlavePresentN));
  // Free-running clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hung handshake would stall the run, so cap it well past the tests.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errorCnt++;
      wrapUp();
    end
  end
  // Prints the verdict and ends the run.
  task automatic wrapUp();
    if (errorCnt == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Lets n edges pass, then samples mid-cycle where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One host access; the decode needs one host edge and three card edges.
  task automatic access(input mode_type m, input logic [10:0] a,
                        input logic attr);
    @(posedge clk);
    mode <= m;
    hostAddress <= a;
    attributeAccess <= attr;
    settle(6);
  endtask
  // Flips ready or write protect once and counts alert cycles on both ends.
  task automatic alert(input mode_type m, input logic [7:0] cfg,
                       input logic wp, input int exp);
    int n;
    @(posedge clk);
    mode <= m;
    configStatus <= cfg;
    settle(2);
    @(posedge clk);
    if (wp) writeProtect <= !writeProtect;
    else cardReady <= !cardReady;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += int'(statusChangedN === 1'b0);
      n += int'(pins.batteryDetectOne === 1'b0);
      n += int'(statusAlert === 1'b1);
    end
    `CHECK(n, exp)
  endtask
  // Sets up the master and slave handshake in task-file mode.
  task automatic shake(input logic master, busy, cardDiag, hostDiag);
    @(posedge clk);
    mode <= MODE_TASKFILE;
    selectMaster <= master;
    driveBusy <= busy;
    passDiagDrive <= cardDiag;
    hostDiagDrive <= hostDiag;
    settle(10);
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    mode = MODE_MEMORY;
    {cardReady, writeProtect, driveBusy, passDiagDrive} = 4'h0;
    {attributeAccess, selectMaster, hostDiagDrive} = 3'h0;
    configStatus = 8'h00;
    hostAddress = 11'h000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    settle(4);
    `CHECK(cardInserted, 1'b1)
    `CHECK({pins.batteryDetectOne, pins.batteryDetectTwo}, 2'h3)
    access(MODE_MEMORY, 11'h1FF, 1'b1);
    `CHECK(region, REGION_CIS)
    access(MODE_MEMORY, 11'h123, 1'b0);
    `CHECK(region, REGION_MEM_PORT)
    access(MODE_IO, 11'h7FF, 1'b0);
    `CHECK(region, REGION_IO_PORT)
    `CHECK(audioOutN, 1'b1)
    access(MODE_IO, 11'h200, 1'b1);
    `CHECK(region, REGION_CONFIG)
    access(MODE_TASKFILE, 11'h7FD, 1'b0);
    `CHECK(taskRegSel, 3'h5)
    `CHECK(pins.cardAddressBus, 11'h005)
    `CHECK(region, REGION_IO_PORT)
    alert(MODE_IO, 8'h40, 1'b0, 3);
    alert(MODE_IO, 8'h40, 1'b1, 3);
    alert(MODE_IO, 8'h00, 1'b0, 0);
    alert(MODE_MEMORY, 8'h40, 1'b1, 0);
    shake(1'b1, 1'b0, 1'b0, 1'b0);
    `CHECK({isMaster, driveActiveSeen, peerDiagPassed}, 3'h4)
    shake(1'b1, 1'b1, 1'b0, 1'b0);
    `CHECK({driveActiveSeen, pins.driveActiveSlavePresentN}, 2'h2)
    shake(1'b0, 1'b0, 1'b1, 1'b0);
    `CHECK({isMaster, slaveSeen, driveActiveSeen}, 3'h3)
    `CHECK(peerDiagPassed, 1'b1)
    shake(1'b1, 1'b0, 1'b0, 1'b1);
    `CHECK({peerDiagPassed, pins.passDiagnosticN}, 2'h2)
    wrapUp();
  end
endmodule

// ### shared/card_pin_if.sv
// Interface carrying the card pins between socket and card.
`timescale 1ns/10ps
interface card_pin_if;
  import card_pin_pkg::*;
  logic [10:0] cardAddressBus;
  logic attributeSelectN;
  logic batteryDetectOne;
  logic batteryDetectTwo;
  logic cardDetectOneN;
  logic cardDetectTwoN;
  logic cableSelectN;
  // Open-drain handshake pins, each party with its own drive and enable.
  logic passDiagCardOut;
  logic passDiagCardOe;
  logic passDiagHostOut;
  logic passDiagHostOe;
  logic driveActiveCardOut;
  logic driveActiveCardOe;
  logic driveActiveHostOut;
  logic driveActiveHostOe;
  logic passDiagnosticN;
  logic driveActiveSlavePresentN;
  // Resolved wire levels; an undriven pin is pulled high.
  assign passDiagnosticN = !((passDiagCardOe && !passDiagCardOut) ||
                             (passDiagHostOe && !passDiagHostOut));
  assign driveActiveSlavePresentN =
    !((driveActiveCardOe && !driveActiveCardOut) ||
      (driveActiveHostOe && !driveActiveHostOut));
  modport card (
    input cardAddressBus, attributeSelectN, cableSelectN,
    input passDiagnosticN, driveActiveSlavePresentN,
    output batteryDetectOne, batteryDetectTwo,
    output cardDetectOneN, cardDetectTwoN,
    output passDiagCardOut, passDiagCardOe,
    output driveActiveCardOut, driveActiveCardOe
  );
  modport host (
    output cardAddressBus, attributeSelectN, cableSelectN,
    input passDiagnosticN, driveActiveSlavePresentN,
    input batteryDetectOne, batteryDetectTwo,
    input cardDetectOneN, cardDetectTwoN,
    output passDiagHostOut, passDiagHostOe,
    output driveActiveHostOut, driveActiveHostOe
  );
endinterface

// ### shared/card_pin_params.svh
// Constants shared by both ends of the card pin function logic.
`ifndef CARD_PIN_PARAMS_SVH
`define CARD_PIN_PARAMS_SVH
`define ADDR_WIDTH 11
`define TASK_SEL_WIDTH 3
`define UPPER_ADDR_LSB 3
`define UPPER_ADDR_MSB 10
`define REGION_IO_LSB 0
`define ATTR_CIS_LIMIT 11'h200
`define CCSR_READY_BIT 0
`define CCSR_WPROT_BIT 1
`define CCSR_CHGEN_BIT 6
`define CCSR_WIDTH 8
`define ADDR_RESET 11'h000
`define UPPER_ZERO 8'h00
`define CTL_IDLE 3'h7
`define CTL_ATTR_BIT 2
`define CTL_CABLE_SELECT_N_BIT 1
`define CTL_DIAG_BIT 0
`define HOST_IN_IDLE 4'hF
`define HOST_CD1_BIT 3
`define HOST_CD2_BIT 2
`define HOST_ALERT_BIT 1
`define HOST_ACTIVE_BIT 0
`endif

// ### shared/card_pin_pkg.sv
// Types shared by both ends of the card pin function logic.
package card_pin_pkg;
  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_IO,
    MODE_TASKFILE
  } mode_type;
  typedef enum logic [1:0] {
    REGION_IO_PORT,
    REGION_MEM_PORT,
    REGION_CIS,
    REGION_CONFIG
  } region_type;
endpackage
